// *** bench/cpd_decoder_sva.sv ***
// port-level assertions for the control and operand decoder
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder_sva (
  input wire logic clock, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [7:0] code_byte, // instruction byte
  input wire logic code_valid, // byte present
  input wire logic code_ready, // byte taken
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata, // read data
  input wire logic busy, // in progress
  input wire logic done, // complete pulse
  input wire logic unknown_op, // unhandled pulse
  input wire logic carry, // carry flag
  input wire logic direction, // direction flag
  input wire logic bus_lock, // lock level
  input wire logic cop_valid // handoff pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic take_op;
  // an opcode is only taken from idle or in the done cycle
  assign take_op = code_valid && code_ready && !busy;
  done_single_a: assert property (done |=> !done) else $error("done held two cycles");
  done_idle_a: assert property (done |-> !busy && code_ready) else $error("busy at done");
  cop_done_a: assert property (cop_valid |-> done) else $error("handoff without done");
  unknown_done_a: assert property (take_op && code_byte == 8'h90 |-> ##2 (done && unknown_op))
    else $error("unknown opcode timing");
  carry_invert_a: assert property (take_op && code_byte == 8'hF5 |=>
    busy ##1 (done && carry == !$past(carry, 2))) else $error("carry invert");
  carry_set_a: assert property (take_op && code_byte == 8'hF9 |->
    ##2 (done && carry && direction == $past(direction, 2))) else $error("carry set");
  lock_prefix_a: assert property (take_op && code_byte == 8'hF0 |->
    ##[2:3] (done && bus_lock)) else $error("lock prefix");
  handoff_cost_a: assert property (take_op && code_byte[7:3] == cpd_pkg::OP_COPROC_HIGH5 |=>
    !done [*5] ##[1:20] (done && cop_valid)) else $error("handoff cost");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray rdata");
endmodule : cpd_decoder_sva
`default_nettype wire

// *** bench/cpd_decoder_test.sv ***
// self-checking bench for the control and operand decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module cpd_decoder_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] code_byte = 8'h00;
  logic code_valid = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic code_ready, busy, done, unknown_op, carry, direction, intr_enable, bus_lock;
  logic cop_valid, operand_is_reg, ovr, dir, r;
  logic [15:0] reg_rdata, effective_address, operand_value, d, ea, rv;
  logic [5:0] cop_opcode;
  logic [19:0] phys_addr, pa;
  logic [1:0] seg_sel, sg, es;
  logic [2:0] cfg;
  logic [2:0] flg = 3'h0;
  logic [7:0] op, mrm;
  logic [15:0] gpr [8];
  logic [15:0] seg [4];
  logic [7:0] bytes [$];
  logic [7:0] ops [11] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hF5, 8'hF5, 8'hF0,
    8'hF0, 8'h90};
  int errors = 0;
  int checks_done = 0;
  time t0;
  always #50 clock = ~clock;
  cpd_decoder dut_u (.clock(clock), .rst_n(rst_n), .code_byte(code_byte),
    .code_valid(code_valid), .code_ready(code_ready), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy), .done(done), .unknown_op(unknown_op), .carry(carry), .direction(direction),
    .intr_enable(intr_enable), .bus_lock(bus_lock), .cop_valid(cop_valid),
    .cop_opcode(cop_opcode), .effective_address(effective_address), .phys_addr(phys_addr),
    .seg_sel(seg_sel), .operand_is_reg(operand_is_reg), .operand_value(operand_value));
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    `CHK(reg_rdata, e, "register read")
    @(posedge clock);
  endtask : rd
  // sends the queued bytes back to back, then times done from the opcode edge
  task automatic run(input int cost);
    int n;
    @(posedge clock);
    for (int i = 0; i < bytes.size(); i++) begin
      code_byte <= bytes[i];
      code_valid <= 1'b1;
      n = 0;
      do begin
        @(negedge clock);
        r = code_ready;
        @(posedge clock);
        n++;
      end while (r !== 1'b1 && n < 50);
      if (r !== 1'b1) begin
        errors++;
        tally_and_finish();
      end
      if (i == 0) t0 = $time;
    end
    code_valid <= 1'b0;
    code_byte <= ~code_byte;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (done !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
    // opcode cycle counts as cycle 0, done stands in cycle cost
    `CHK(($time - t0 + 50) / 100, cost, "cycle count")
    bytes.delete();
  endtask : run
  function automatic logic [15:0] base(input logic [2:0] rm);
    logic [15:0] b [8];
    b = '{gpr[3] + gpr[6], gpr[3] + gpr[7], gpr[5] + gpr[6], gpr[5] + gpr[7], gpr[6], gpr[7],
      gpr[5], gpr[3]};
    return b[rm];
  endfunction : base
  initial begin
    void'($urandom(93180));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK({code_ready, seg_sel, done, busy, carry}, 6'h38, "reset outputs")
    @(posedge clock);
    for (int i = 0; i < 12; i++) begin
      if (i < 8) gpr[i] = 16'($urandom);
      else seg[i - 8] = 16'($urandom);
      wr(5'(i), i < 8 ? gpr[i] : seg[i - 8]);
    end
    rd(cpd_pkg::REG_FLAGS, 16'h0000);
    rd(5'h1F, 16'h0000);
    rd(5'h03, gpr[3]);
    foreach (ops[k]) begin
      cfg = 3'(k);
      wr(cpd_pkg::REG_CONFIG, {13'h0000, cfg});
      bytes.push_back(ops[k]);
      if (ops[k][7:3] == 5'h1F) begin
        flg[ops[k][2:1] == 2'h0 ? 0 : ops[k][2:1] == 2'h1 ? 2 : 1] = ops[k][0];
      end
      if (ops[k] == 8'hF5) flg[0] = ~flg[0];
      run(ops[k] == 8'hF0 && cfg[0] ? 3 : 2);
      `CHK({intr_enable, direction, carry}, flg, "flag bits")
      `CHK(unknown_op, ops[k] == 8'h90, "unknown flag")
      if (ops[k] == 8'hF0) `CHK(bus_lock, 1'b1, "lock level")
    end
    rd(cpd_pkg::REG_FLAGS, {13'h0000, flg});
    for (int k = 0; k < 24; k++) begin
      op = {5'h1B, 3'($urandom)};
      mrm = 8'($urandom);
      cfg = 3'($urandom);
      d = 16'($urandom);
      ovr = 1'($urandom);
      sg = 2'($urandom);
      wr(cpd_pkg::REG_CONFIG, {13'h0000, cfg});
      if (ovr) bytes.push_back({3'h1, sg, 3'h6});
      if (ovr) run(2);
      bytes.push_back(op);
      bytes.push_back(mrm);
      dir = mrm[7:6] == 2'h0 && mrm[2:0] == 3'h6;
      if (mrm[7:6] == 2'h1) d = {{8{d[7]}}, d[7:0]};
      if (mrm[7:6] == 2'h0 && !dir) d = 16'h0000;
      if (mrm[7:6] != 2'h3 && (mrm[7:6] != 2'h0 || dir)) bytes.push_back(d[7:0]);
      if (mrm[7:6] == 2'h2 || dir) bytes.push_back(d[15:8]);
      ea = (dir ? 16'h0000 : base(mrm[2:0])) + d;
      es = cfg[2] ? 2'h0 : ovr ? sg :
        (mrm[2:1] == 2'h1 || (mrm[2:0] == 3'h6 && !dir)) ? 2'h2 : 2'h3;
      run(mrm[7:6] != 2'h3 && cfg[1] ? 10 : 6);
      `CHK({cop_valid, cop_opcode}, {1'b1, op[2:0], mrm[5:3]}, "handoff opcode")
      rv = gpr[mrm[2:0]];
      if (!cfg[1]) rv = {8'h00, mrm[2] ? gpr[mrm[1:0]][15:8] : gpr[mrm[1:0]][7:0]};
      if (mrm[7:6] == 2'h3) begin
        `CHK({operand_is_reg, operand_value}, {1'b1, rv}, "reg operand")
      end else begin
        pa = {seg[es], 4'h0} + {4'h0, ea};
        `CHK({operand_is_reg, effective_address}, {1'b0, ea}, "ea")
        `CHK({seg_sel, phys_addr}, {es, pa}, "seg")
      end
    end
    tally_and_finish();
  end
endmodule : cpd_decoder_test
bind cpd_decoder cpd_decoder_sva chk_u (.clock(clock), .rst_n(rst_n), .code_byte(code_byte),
  .code_valid(code_valid), .code_ready(code_ready), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .busy(busy), .done(done), .unknown_op(unknown_op), .carry(carry), .direction(direction),
  .bus_lock(bus_lock), .cop_valid(cop_valid));
`default_nettype wire

// *** core/cpd_decoder.sv ***
// processor-control opcode execution and operand addressing-byte decode
`timescale 1ns/1ps
`default_nettype none
module cpd_decoder (
  input wire logic clock, // 10 MHz processor clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [7:0] code_byte, // next instruction byte
  input wire logic code_valid, // code_byte is present
  output logic code_ready, // decoder takes a byte this cycle
  input wire logic [4:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  output logic busy, // instruction in progress
  output logic done, // instruction complete, one cycle
  output logic unknown_op, // completed opcode was not handled, one cycle
  output logic carry, // carry flag
  output logic direction, // direction flag
  output logic intr_enable, // interrupt-enable flag
  output logic bus_lock, // lock prefix active for the next instruction
  output logic cop_valid, // coprocessor opcode handed off, one cycle
  output logic [5:0] cop_opcode, // high and low opcode bits for the coprocessor
  output logic [15:0] effective_address, // last computed offset
  output logic [19:0] phys_addr, // last physical address
  output logic [1:0] seg_sel, // segment used for the last memory operand
  output logic operand_is_reg, // last operand was a register
  output logic [15:0] operand_value // value of the last register operand
);

  typedef enum logic [4:0] {
    CPD_IDLE = 5'b00001,
    CPD_MODRM = 5'b00010,
    CPD_DISP_LO = 5'b00100,
    CPD_DISP_HI = 5'b01000,
    CPD_EXEC = 5'b10000
  } cpd_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // register field decode by size bit
  function automatic logic [15:0] cpd_reg_value(input logic [2:0] field, input logic wide,
                                                 input logic [15:0] r0, input logic [15:0] r1,
                                                 input logic [15:0] r2, input logic [15:0] r3,
                                                 input logic [15:0] r4, input logic [15:0] r5,
                                                 input logic [15:0] r6, input logic [15:0] r7);
    logic [15:0] word;
    logic [15:0] low4;
    word = 16'h0000;
    low4 = 16'h0000;
    case (field)
      3'h0: word = r0;
      3'h1: word = r1;
      3'h2: word = r2;
      3'h3: word = r3;
      3'h4: word = r4;
      3'h5: word = r5;
      3'h6: word = r6;
      default: word = r7;
    endcase
    case (field[1:0])
      2'h0: low4 = r0;
      2'h1: low4 = r1;
      2'h2: low4 = r2;
      default: low4 = r3;
    endcase
    if (wide) begin
      cpd_reg_value = word;
    end else if (field[2]) begin
      cpd_reg_value = {8'h00, low4[15:8]};
    end else begin
      cpd_reg_value = {8'h00, low4[7:0]};
    end
  endfunction : cpd_reg_value

  // true when the operand field addresses through the base pointer
  function automatic logic cpd_uses_bp(input logic [1:0] md, input logic [2:0] rm);
    cpd_uses_bp = (rm == 3'h2) || (rm == 3'h3) ||
                  ((rm == cpd_pkg::RM_DIRECT) && (md != cpd_pkg::MOD_NO_DISP));
  endfunction : cpd_uses_bp

  ////////////////////////////////////////////////////////////////////////////
  // state

  cpd_state_t state, next_state;
  logic [15:0] gpr [0:7];
  logic [15:0] seg [0:3];
  logic [2:0] flags, next_flags;
  logic [2:0] cfg, next_cfg;
  logic [7:0] opcode, next_opcode;
  logic [7:0] modrm, next_modrm;
  logic [15:0] disp, next_disp;
  logic [7:0] cost, next_cost;
  logic [7:0] cyc, next_cyc;
  logic ovr_pending, next_ovr_pending;
  logic [1:0] ovr_seg, next_ovr_seg;
  logic lock_pending, next_lock_pending;
  logic next_busy, next_done, next_unknown, next_cop_valid, next_ready;
  logic next_bus_lock, next_is_reg;
  logic [5:0] next_cop_opcode;
  logic [15:0] next_ea, next_operand, next_rdata;
  logic [19:0] next_phys;
  logic [1:0] next_seg_sel;

  logic take;
  logic [15:0] base_a, base_b, ea_sum;
  logic [1:0] md;
  logic [2:0] rm;
  logic [1:0] use_seg;

  assign take = code_valid && code_ready;
  assign md = modrm[7:6];
  assign rm = modrm[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // effective address of the held operand byte

  always_comb begin
    base_a = 16'h0000;
    base_b = 16'h0000;
    case (rm)
      3'h0: begin
        base_a = gpr[cpd_pkg::GPR_BASE_WORD];
        base_b = gpr[cpd_pkg::GPR_SOURCE_INDEX];
      end
      3'h1: begin
        base_a = gpr[cpd_pkg::GPR_BASE_WORD];
        base_b = gpr[cpd_pkg::GPR_DESTINATION_INDEX];
      end
      3'h2: begin
        base_a = gpr[cpd_pkg::GPR_BASE_POINTER];
        base_b = gpr[cpd_pkg::GPR_SOURCE_INDEX];
      end
      3'h3: begin
        base_a = gpr[cpd_pkg::GPR_BASE_POINTER];
        base_b = gpr[cpd_pkg::GPR_DESTINATION_INDEX];
      end
      3'h4: base_a = gpr[cpd_pkg::GPR_SOURCE_INDEX];
      3'h5: base_a = gpr[cpd_pkg::GPR_DESTINATION_INDEX];
      3'h6: begin
        // direct form leaves the base at zero so the sum is the address
        if (md != cpd_pkg::MOD_NO_DISP) begin
          base_a = gpr[cpd_pkg::GPR_BASE_POINTER];
        end
      end
      default: base_a = gpr[cpd_pkg::GPR_BASE_WORD];
    endcase
    ea_sum = 16'(base_a + base_b + disp);
    // string destination beats any override; override beats the default
    if (cfg[cpd_pkg::CFG_STRING_DEST]) begin
      use_seg = cpd_pkg::SEG_EXTRA;
    end else if (ovr_pending) begin
      use_seg = ovr_seg;
    end else if (cpd_uses_bp(md, rm)) begin
      use_seg = cpd_pkg::SEG_STACK;
    end else begin
      use_seg = cpd_pkg::SEG_DATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    next_state = state;
    next_flags = flags;
    next_opcode = opcode;
    next_modrm = modrm;
    next_disp = disp;
    next_cost = cost;
    next_cyc = cyc;
    next_ovr_pending = ovr_pending;
    next_ovr_seg = ovr_seg;
    next_lock_pending = lock_pending;
    next_done = 1'b0;
    next_unknown = 1'b0;
    next_cop_valid = 1'b0;
    next_cop_opcode = cop_opcode;
    next_ea = effective_address;
    next_phys = phys_addr;
    next_seg_sel = seg_sel;
    next_is_reg = operand_is_reg;
    next_operand = operand_value;
    if (state != CPD_IDLE) begin
      next_cyc = 8'(cyc + 8'h01);
    end
    case (state)
      CPD_IDLE: begin
        if (take) begin
          next_opcode = code_byte;
          next_cyc = 8'h01;
          next_disp = 16'h0000;
          next_state = CPD_EXEC;
          if (code_byte == cpd_pkg::OP_BUS_LOCK) begin
            next_cost = cfg[cpd_pkg::CFG_NARROW_BUS] ? cpd_pkg::LOCK_CYCLES_NARROW
                                                     : cpd_pkg::LOCK_CYCLES_WIDE;
          end else if (code_byte[7:3] == cpd_pkg::OP_COPROC_HIGH5) begin
            next_cost = cpd_pkg::COPROC_CYCLES;
            next_state = CPD_MODRM;
          end else if (code_byte[7:5] == cpd_pkg::OP_SEG_OVR_HIGH3 &&
                       code_byte[2:0] == cpd_pkg::OP_SEG_OVR_LOW3) begin
            next_cost = cpd_pkg::SEG_OVR_CYCLES;
          end else if (code_byte == cpd_pkg::OP_CARRY_INVERT ||
                       (code_byte >= cpd_pkg::OP_CLEAR_CARRY &&
                        code_byte <= cpd_pkg::OP_SET_DIRECTION)) begin
            next_cost = cpd_pkg::FLAG_OP_CYCLES;
          end else begin
            next_cost = cpd_pkg::UNKNOWN_CYCLES;
          end
        end
      end
      CPD_MODRM: begin
        if (take) begin
          next_modrm = code_byte;
          // memory operand of a word operation costs one more transfer
          if (code_byte[7:6] != cpd_pkg::MOD_REGISTER && cfg[cpd_pkg::CFG_WORD_OP]) begin
            next_cost = 8'(cost + cpd_pkg::WORD_XFER_EXTRA);
          end
          case (code_byte[7:6])
            cpd_pkg::MOD_NO_DISP: begin
              next_state = (code_byte[2:0] == cpd_pkg::RM_DIRECT) ? CPD_DISP_LO : CPD_EXEC;
            end
            cpd_pkg::MOD_DISP8: next_state = CPD_DISP_LO;
            cpd_pkg::MOD_DISP16: next_state = CPD_DISP_LO;
            default: next_state = CPD_EXEC;
          endcase
        end
      end
      CPD_DISP_LO: begin
        if (take) begin
          if (md == cpd_pkg::MOD_DISP8) begin
            next_disp = {{8{code_byte[7]}}, code_byte};
            next_state = CPD_EXEC;
          end else begin
            next_disp = {8'h00, code_byte};
            next_state = CPD_DISP_HI;
          end
        end
      end
      CPD_DISP_HI: begin
        if (take) begin
          next_disp = {code_byte, disp[7:0]};
          next_state = CPD_EXEC;
        end
      end
      CPD_EXEC: begin
        // elapsed count includes the fetch cycles, and address time is
        // part of the coprocessor cost, so no extra wait is added
        if (cyc >= 8'(cost - 8'h01)) begin
          next_state = CPD_IDLE;
          next_done = 1'b1;
          next_cyc = 8'h00;
          if (opcode != cpd_pkg::OP_BUS_LOCK && !(opcode[7:5] == cpd_pkg::OP_SEG_OVR_HIGH3 &&
              opcode[2:0] == cpd_pkg::OP_SEG_OVR_LOW3)) begin
            next_lock_pending = 1'b0;
            next_ovr_pending = 1'b0;
          end
          case (opcode)
            cpd_pkg::OP_CARRY_INVERT: next_flags[cpd_pkg::FLAG_CARRY] = ~flags[cpd_pkg::FLAG_CARRY];
            cpd_pkg::OP_CLEAR_CARRY: next_flags[cpd_pkg::FLAG_CARRY] = 1'b0;
            cpd_pkg::OP_SET_CARRY: next_flags[cpd_pkg::FLAG_CARRY] = 1'b1;
            cpd_pkg::OP_INTERRUPT_MASK: next_flags[cpd_pkg::FLAG_INTR] = 1'b0;
            cpd_pkg::OP_INTERRUPT_UNMASK: next_flags[cpd_pkg::FLAG_INTR] = 1'b1;
            cpd_pkg::OP_CLEAR_DIRECTION: next_flags[cpd_pkg::FLAG_DIRECTION] = 1'b0;
            cpd_pkg::OP_SET_DIRECTION: next_flags[cpd_pkg::FLAG_DIRECTION] = 1'b1;
            cpd_pkg::OP_BUS_LOCK: next_lock_pending = 1'b1;
            default: begin
              if (opcode[7:3] == cpd_pkg::OP_COPROC_HIGH5) begin
                next_cop_valid = 1'b1;
                next_cop_opcode = {opcode[2:0], modrm[5:3]};
                if (md == cpd_pkg::MOD_REGISTER) begin
                  next_is_reg = 1'b1;
                  next_operand = cpd_reg_value(rm, cfg[cpd_pkg::CFG_WORD_OP], gpr[0], gpr[1],
                                               gpr[2], gpr[3], gpr[4], gpr[5], gpr[6], gpr[7]);
                end else begin
                  next_is_reg = 1'b0;
                  next_ea = ea_sum;
                  next_seg_sel = use_seg;
                  next_phys = 20'({seg[use_seg], 4'h0} + {4'h0, ea_sum});
                end
              end else if (opcode[7:5] == cpd_pkg::OP_SEG_OVR_HIGH3 &&
                           opcode[2:0] == cpd_pkg::OP_SEG_OVR_LOW3) begin
                next_ovr_pending = 1'b1;
                next_ovr_seg = opcode[4:3];
              end else begin
                next_unknown = 1'b1;
              end
            end
          endcase
        end
      end
      default: next_state = CPD_IDLE;
    endcase
    // hardware flag update wins over a software write in the same cycle
    next_cfg = cfg;
    if (reg_wr && reg_addr == cpd_pkg::REG_CONFIG) begin
      next_cfg = reg_wdata[2:0];
    end
    if (reg_wr && reg_addr == cpd_pkg::REG_FLAGS && !next_done) begin
      next_flags = reg_wdata[2:0];
    end
    next_busy = (next_state != CPD_IDLE);
    next_ready = (next_state != CPD_EXEC);
    next_bus_lock = next_lock_pending;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr < cpd_pkg::REG_SEG0) begin
        next_rdata = gpr[reg_addr[2:0]];
      end else if (reg_addr < cpd_pkg::REG_FLAGS) begin
        next_rdata = seg[reg_addr[1:0]];
      end else begin
        case (reg_addr)
          cpd_pkg::REG_FLAGS: next_rdata = {13'h0000, flags};
          cpd_pkg::REG_CONFIG: next_rdata = {13'h0000, cfg};
          cpd_pkg::REG_EA: next_rdata = effective_address;
          cpd_pkg::REG_PHYS_LO: next_rdata = phys_addr[15:0];
          cpd_pkg::REG_PHYS_HI: next_rdata = {12'h000, phys_addr[19:16]};
          cpd_pkg::REG_DECODE: next_rdata = {5'h00, busy, bus_lock, operand_is_reg,
                                             seg_sel, cop_opcode};
          cpd_pkg::REG_OPERAND: next_rdata = operand_value;
          default: next_rdata = 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gpr
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          gpr[gi] <= cpd_pkg::REG_RESET;
        end else if (reg_wr && reg_addr == 5'(cpd_pkg::REG_GPR0 + gi)) begin
          gpr[gi] <= reg_wdata;
        end
      end
    end
    for (gi = 0; gi < 4; gi++) begin : g_seg
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          seg[gi] <= cpd_pkg::REG_RESET;
        end else if (reg_wr && reg_addr == 5'(cpd_pkg::REG_SEG0 + gi)) begin
          seg[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= CPD_IDLE;
      flags <= cpd_pkg::FLAGS_RESET;
      cfg <= cpd_pkg::CONFIG_RESET;
      opcode <= 8'h00;
      modrm <= 8'h00;
      disp <= 16'h0000;
      cost <= 8'h00;
      cyc <= 8'h00;
      ovr_pending <= 1'b0;
      ovr_seg <= cpd_pkg::SEG_DATA;
      lock_pending <= 1'b0;
      code_ready <= 1'b1;
      reg_rdata <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      unknown_op <= 1'b0;
      bus_lock <= 1'b0;
      cop_valid <= 1'b0;
      cop_opcode <= 6'h00;
      effective_address <= 16'h0000;
      phys_addr <= 20'h00000;
      seg_sel <= cpd_pkg::SEG_DATA;
      operand_is_reg <= 1'b0;
      operand_value <= 16'h0000;
    end else begin
      state <= next_state;
      flags <= next_flags;
      cfg <= next_cfg;
      opcode <= next_opcode;
      modrm <= next_modrm;
      disp <= next_disp;
      cost <= next_cost;
      cyc <= next_cyc;
      ovr_pending <= next_ovr_pending;
      ovr_seg <= next_ovr_seg;
      lock_pending <= next_lock_pending;
      code_ready <= next_ready;
      reg_rdata <= next_rdata;
      busy <= next_busy;
      done <= next_done;
      unknown_op <= next_unknown;
      bus_lock <= next_bus_lock;
      cop_valid <= next_cop_valid;
      cop_opcode <= next_cop_opcode;
      effective_address <= next_ea;
      phys_addr <= next_phys;
      seg_sel <= next_seg_sel;
      operand_is_reg <= next_is_reg;
      operand_value <= next_operand;
    end
  end

  assign carry = flags[cpd_pkg::FLAG_CARRY];
  assign direction = flags[cpd_pkg::FLAG_DIRECTION];
  assign intr_enable = flags[cpd_pkg::FLAG_INTR];

endmodule : cpd_decoder
`default_nettype wire

// *** core/cpd_pkg.sv ***
// constants, opcodes and register map of the control and operand decoder
// Notes on behaviour
// - carry_invert_op (opcode F5) toggles carry and takes 2 cycles.
// - carry, direction and interrupt clear or set ops take 2 cycles, one flag each.
// - opcode F0 is the bus-lock prefix: 2 cycles, 3 on the narrow-bus variant.
// - opcode 11011xxx plus operand byte is a coprocessor handoff of 6 cycles.
// - word operations add 4 cycles for each memory transfer.
// - effective-address calculation costs 4 cycles, included in the counts.
// - addressing form 11 makes the operand field a register selector.
// - form 00 has no displacement, except field 110 takes a direct 16-bit address.
// - form 01 takes one displacement byte, sign-extended to 16 bits.
// - form 10 takes two displacement bytes, low byte first.
// - fields 000/001 give base word plus source or destination index plus displacement.
// - fields 010/011 give base pointer plus source or destination index plus displacement.
// - fields 100..111 give source index, destination index, base pointer, base word.
// - segment field: 00 extra, 01 code, 10 stack, 11 data, also in prefixes.
// - register field decodes word or byte registers by the size bit.
// - operands addressed through the base pointer default to the stack segment.
// - string destinations always use the extra segment, overrides ignored.
// - displacement bytes are fetched right after the operand byte.
package cpd_pkg;
  // opcodes
  localparam logic [7:0] OP_CLEAR_CARRY = 8'hF8;
  localparam logic [7:0] OP_SET_CARRY = 8'hF9;
  localparam logic [7:0] OP_INTERRUPT_MASK = 8'hFA;
  localparam logic [7:0] OP_INTERRUPT_UNMASK = 8'hFB;
  localparam logic [7:0] OP_CLEAR_DIRECTION = 8'hFC;
  localparam logic [7:0] OP_SET_DIRECTION = 8'hFD;
  localparam logic [7:0] OP_CARRY_INVERT = 8'hF5;
  localparam logic [7:0] OP_BUS_LOCK = 8'hF0;
  localparam logic [4:0] OP_COPROC_HIGH5 = 5'h1B;
  localparam logic [2:0] OP_SEG_OVR_HIGH3 = 3'h1;
  localparam logic [2:0] OP_SEG_OVR_LOW3 = 3'h6;
  // addressing forms
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REGISTER = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  // segment selector codes
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  // general register indices
  localparam logic [2:0] GPR_BASE_WORD = 3'h3;
  localparam logic [2:0] GPR_BASE_POINTER = 3'h5;
  localparam logic [2:0] GPR_SOURCE_INDEX = 3'h6;
  localparam logic [2:0] GPR_DESTINATION_INDEX = 3'h7;
  // cycle costs
  localparam logic [7:0] FLAG_OP_CYCLES = 8'h02;
  localparam logic [7:0] LOCK_CYCLES_WIDE = 8'h02;
  localparam logic [7:0] LOCK_CYCLES_NARROW = 8'h03;
  localparam logic [7:0] COPROC_CYCLES = 8'h06;
  localparam logic [7:0] WORD_XFER_EXTRA = 8'h04;
  localparam logic [7:0] EA_CYCLES = 8'h04;
  localparam logic [7:0] SEG_OVR_CYCLES = 8'h02;
  localparam logic [7:0] UNKNOWN_CYCLES = 8'h02;
  // register map, word indices on the register port
  localparam logic [4:0] REG_GPR0 = 5'h00;
  localparam logic [4:0] REG_SEG0 = 5'h08;
  localparam logic [4:0] REG_FLAGS = 5'h0C;
  localparam logic [4:0] REG_CONFIG = 5'h0D;
  localparam logic [4:0] REG_EA = 5'h0E;
  localparam logic [4:0] REG_PHYS_LO = 5'h0F;
  localparam logic [4:0] REG_PHYS_HI = 5'h10;
  localparam logic [4:0] REG_DECODE = 5'h11;
  localparam logic [4:0] REG_OPERAND = 5'h12;
  // flag and config bit positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIRECTION = 1;
  localparam int FLAG_INTR = 2;
  localparam int CFG_NARROW_BUS = 0;
  localparam int CFG_WORD_OP = 1;
  localparam int CFG_STRING_DEST = 2;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [2:0] CONFIG_RESET = 3'h0;
  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : cpd_pkg
